// ---- codec_pkg.sv ----
// Shared constants for the start-stop five-element line codec.
package codec_pkg;

    localparam int          CLK_PERIOD_NS   = 5;
    localparam longint      NS_PER_MIN      = 64'd60000000000;
    localparam int          OPM_368         = 368;
    localparam int          OPM_460         = 460;
    localparam int          OPM_600         = 600;
    localparam int          UNIT_X100       = 100;
    localparam int          CHAR_UNITS_X100 = 742;
    localparam int          STOP_UNITS_X100 = 142;
    localparam int          DATA_BITS       = 5;
    localparam int          CNT_W           = 23;
    localparam logic [2:0]  LAST_BIT        = 3'h4;
    localparam logic [1:0]  SPEED_368       = 2'h0;
    localparam logic [1:0]  SPEED_460       = 2'h1;
    localparam logic [1:0]  SPEED_600       = 2'h2;
    localparam logic        LINE_MARK       = 1'b1;
    localparam logic        LINE_SPACE      = 1'b0;

    // One unit is a character period divided by 7.42, counted in clock cycles.
    function automatic int unit_cycles(input int opm);
        longint num;
        longint den;
        num = NS_PER_MIN * UNIT_X100;
        den = longint'(opm) * CHAR_UNITS_X100 * CLK_PERIOD_NS;
        return int'(num / den);
    endfunction

endpackage

// ---- remote_line_partner.sv ----
// Remote start-stop transmitter model that keys the receive line.
`timescale 1ns/100ps
module remote_line_partner
    import codec_pkg::*;
(
    input  wire logic clk_i,
    output logic      line_o
);
    // ****************************************
    // Line keying
    // ****************************************
    // The loop idles with current flowing.
    initial line_o = LINE_MARK;
    // Levels change just after the falling edge, clear of the sampling edge.
    task automatic hold(input logic lvl, input int n);
        line_o = lvl;
        repeat (n) @(negedge clk_i);
    endtask
    task automatic send(input logic [DATA_BITS-1:0] d, input int u, input int s,
                        input logic stop_lvl);
        hold(LINE_SPACE, u);
        for (int i = 0; i < DATA_BITS; i++) begin
            hold(d[i], u);
        end
        hold(stop_lvl, s);
        // A spacing stop is followed by one marking cycle so the next start edge is seen.
        if (stop_lvl != LINE_MARK) hold(LINE_MARK, 1);
    endtask
endmodule // remote_line_partner

// ---- start_stop_codec.sv ----
// Transmit and receive framing for the start-stop five-element line code.
// Function
// - Current is marking, no current is spacing.
// - Each character starts with one spacing unit.
// - Then exactly five one-unit selecting elements.
// - Marking stop lasts 1.42 units; 7.42 total.
// - 368 opm default; 460 or 600 selectable.
// - Dot cycle 22.8, 28.4, 37.1 Hz.
// - Receiver resynchronises on every start interval.
`timescale 1ns/100ps
module start_stop_codec
    import codec_pkg::*;
#(
    parameter int UNIT_CYC_368 = unit_cycles(OPM_368),
    parameter int UNIT_CYC_460 = unit_cycles(OPM_460),
    parameter int UNIT_CYC_600 = unit_cycles(OPM_600)
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [1:0]           speed_sel_i,
    input  wire logic [DATA_BITS-1:0] tx_data_i,
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    output logic                      line_tx_o,
    input  wire logic                 line_rx_i,
    output logic [DATA_BITS-1:0]      rx_data_o,
    output logic                      rx_valid_o,
    output logic                      rx_frame_err_o
);

    // ************************************************************
    // Speed decode
    // ************************************************************
    // An unused select code falls back to the default rate.
    function automatic logic [CNT_W-1:0] unit_len(input logic [1:0] sel);
        unique case (sel)
            SPEED_460: return CNT_W'(UNIT_CYC_460);
            SPEED_600: return CNT_W'(UNIT_CYC_600);
            default:   return CNT_W'(UNIT_CYC_368);
        endcase
    endfunction
    function automatic logic [CNT_W-1:0] stop_len(input logic [CNT_W-1:0] unit);
        return CNT_W'((int'(unit) * STOP_UNITS_X100) / UNIT_X100);
    endfunction

    // ************************************************************
    // Transmitter
    // ************************************************************
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
    tx_state_e              tx_st_q;
    tx_state_e              tx_st_d;
    logic [DATA_BITS-1:0]   tx_sh_q;
    logic [DATA_BITS-1:0]   tx_sh_d;
    logic [2:0]             tx_bit_q;
    logic [2:0]             tx_bit_d;
    logic [CNT_W-1:0]       tx_unit_q;
    logic [CNT_W-1:0]       tx_len;
    logic                   tx_load;
    logic                   tx_done;
    logic                   tx_line_d;
    always_comb begin
        tx_st_d  = tx_st_q;
        tx_sh_d  = tx_sh_q;
        tx_bit_d = tx_bit_q;
        tx_load  = 1'b0;
        tx_len   = tx_unit_q - CNT_W'(1);
        unique case (tx_st_q)
            TX_IDLE: begin
                if (tx_valid_i) begin
                    tx_st_d = TX_START;
                    tx_sh_d = tx_data_i;
                    tx_load = 1'b1;
                    tx_len  = unit_len(speed_sel_i) - CNT_W'(1);
                end
            end
            TX_START: begin
                if (tx_done) begin
                    tx_st_d  = TX_DATA;
                    tx_bit_d = 3'h0;
                    tx_load  = 1'b1;
                end
            end
            TX_DATA: begin
                if (tx_done) begin
                    tx_load = 1'b1;
                    if (tx_bit_q == LAST_BIT) begin
                        tx_st_d = TX_STOP;
                        tx_len  = stop_len(tx_unit_q) - CNT_W'(1);
                    end else begin
                        tx_bit_d = tx_bit_q + 3'h1;
                        tx_sh_d  = tx_sh_q >> 1;
                    end
                end
            end
            TX_STOP: begin
                if (tx_done) begin
                    tx_st_d = TX_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        unique case (tx_st_d)
            TX_START: tx_line_d = LINE_SPACE;
            TX_DATA:  tx_line_d = tx_sh_d[0];
            default:  tx_line_d = LINE_MARK;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_st_q  <= TX_IDLE;
            tx_sh_q  <= '0;
            tx_bit_q <= 3'h0;
        end else begin
            tx_st_q  <= tx_st_d;
            tx_sh_q  <= tx_sh_d;
            tx_bit_q <= tx_bit_d;
        end
    end

    // The rate is frozen per character so a select change cannot stretch a frame.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_unit_q <= CNT_W'(UNIT_CYC_368);
        end else if (tx_st_q == TX_IDLE && tx_valid_i) begin
            tx_unit_q <= unit_len(speed_sel_i);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_tx_o  <= LINE_MARK;
            tx_ready_o <= 1'b1;
        end else begin
            line_tx_o  <= tx_line_d;
            tx_ready_o <= (tx_st_d == TX_IDLE);
        end
    end

    unit_timer u_tx_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (tx_load),
        .count_i   (tx_len),
        .done_o    (tx_done)
    );

    // ************************************************************
    // Receiver
    // ************************************************************
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
    rx_state_e              rx_st_q;
    logic                   rx_prev_q;
    logic [DATA_BITS-1:0]   rx_sh_q;
    logic [2:0]             rx_bit_q;
    logic [CNT_W-1:0]       rx_unit_q;
    logic [CNT_W-1:0]       rx_len;
    logic                   rx_load;
    logic                   rx_done;
    logic                   rx_fall;
    assign rx_fall = (rx_prev_q == LINE_MARK) && (line_rx_i == LINE_SPACE);

    always_comb begin
        rx_load = 1'b0;
        rx_len  = rx_unit_q - CNT_W'(1);
        if (rx_st_q == RX_IDLE && rx_fall) begin
            rx_load = 1'b1;
            rx_len  = (unit_len(speed_sel_i) >> 1) - CNT_W'(1);
        end else if (rx_done && rx_st_q != RX_STOP) begin
            rx_load = (rx_st_q == RX_DATA) || (line_rx_i == LINE_SPACE);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_prev_q <= LINE_MARK;
        end else begin
            rx_prev_q <= line_rx_i;
        end
    end

    // A start that is no longer spacing at mid-unit is treated as noise.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_st_q  <= RX_IDLE;
            rx_bit_q <= 3'h0;
            rx_sh_q  <= '0;
        end else begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    if (rx_fall) begin
                        rx_st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_done) begin
                        rx_st_q  <= (line_rx_i == LINE_SPACE) ? RX_DATA : RX_IDLE;
                        rx_bit_q <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_done) begin
                        rx_sh_q  <= {line_rx_i, rx_sh_q[DATA_BITS-1:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == LAST_BIT) begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_done) begin
                        rx_st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_unit_q <= CNT_W'(UNIT_CYC_368);
        end else if (rx_st_q == RX_IDLE && rx_fall) begin
            rx_unit_q <= unit_len(speed_sel_i);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_valid_o     <= 1'b0;
            rx_frame_err_o <= 1'b0;
            rx_data_o      <= '0;
        end else begin
            rx_valid_o     <= (rx_st_q == RX_STOP) && rx_done;
            rx_frame_err_o <= (rx_st_q == RX_STOP) && rx_done && (line_rx_i == LINE_SPACE);
            if (rx_st_q == RX_STOP && rx_done) begin
                rx_data_o <= rx_sh_q;
            end
        end
    end

    unit_timer u_rx_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (rx_load),
        .count_i   (rx_len),
        .done_o    (rx_done)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    logic [CNT_W-1:0] dur_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dur_q <= CNT_W'(1);
        end else if (tx_st_d != tx_st_q || (tx_st_q == TX_DATA && tx_done)) begin
            dur_q <= CNT_W'(1);
        end else begin
            dur_q <= dur_q + CNT_W'(1);
        end
    end

    a_idle_marking: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_IDLE || tx_st_q == TX_STOP) |-> line_tx_o == LINE_MARK)
        else $error("line not marking while idle or in stop");
    a_start_unit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_START && tx_done) |-> (dur_q == tx_unit_q && line_tx_o == LINE_SPACE))
        else $error("start interval not one spacing unit");
    a_five_elements: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_DATA && tx_done && tx_bit_q == LAST_BIT) |=> tx_st_q == TX_STOP)
        else $error("stop did not follow the fifth element");
    a_stop_length: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_STOP && tx_done) |-> dur_q == stop_len(tx_unit_q))
        else $error("stop interval length wrong");
    a_speed_latch: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_IDLE && tx_valid_i) |=> tx_unit_q == unit_len($past(speed_sel_i)))
        else $error("character rate not taken from select");
    a_element_unit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_DATA && tx_done) |-> (dur_q == tx_unit_q && line_tx_o == tx_sh_q[0]))
        else $error("element length or level wrong");
    a_rx_resync: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rx_st_q == RX_IDLE && rx_fall) |=> (rx_st_q == RX_START) [*2])
        else $error("receiver missed a start transition");
    a_rx_one_pulse: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        rx_valid_o |-> ($past(rx_st_q) == RX_STOP && rx_st_q == RX_IDLE) ##1 !rx_valid_o)
        else $error("receive strobe not a single cycle after stop");

endmodule // start_stop_codec

// ---- start_stop_five_unit_codec_test.sv ----
// Self-checking testbench for the start-stop five-element line codec.
`timescale 1ns/100ps
module start_stop_five_unit_codec_test
    import codec_pkg::*;
;
    // ****************************************
    // Stimulus and design
    // ****************************************
    localparam int U0 = 40;
    localparam int U1 = 32;
    localparam int U2 = 24;
    logic                 clk_i       = 1'b0;
    logic                 sys_rst_i   = 1'b1;
    logic [1:0]           speed_sel_i = 2'h0;
    logic [DATA_BITS-1:0] tx_data_i   = 5'h00;
    logic                 tx_valid_i  = 1'b0;
    logic                 tx_ready_o;
    logic                 line_tx_o;
    logic                 line_rx;
    logic [DATA_BITS-1:0] rx_data_o;
    logic                 rx_valid_o;
    logic                 rx_frame_err_o;
    int                   bad_count   = 0;
    int                   tests_run   = 0;
    always #2.5 clk_i = ~clk_i;
    // Short units keep the run brief; every expectation derives from them.
    start_stop_codec #(.UNIT_CYC_368(U0), .UNIT_CYC_460(U1), .UNIT_CYC_600(U2)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .speed_sel_i(speed_sel_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .line_tx_o(line_tx_o), .line_rx_i(line_rx), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_frame_err_o(rx_frame_err_o));
    remote_line_partner partner_u (.clk_i(clk_i), .line_o(line_rx));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic int ucyc(input logic [1:0] sel);
        return (sel == SPEED_460) ? U1 : (sel == SPEED_600) ? U2 : U0;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        finish_test();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_values();
        check({tx_ready_o, line_tx_o, rx_valid_o, rx_frame_err_o}, 8'h0c);
        check(rx_data_o, 8'h00);
        $display("test reset_values done");
    endtask
    // Sends one character; returns at the edge where the transmitter is free.
    task automatic tx_char(input logic [1:0] sel, input logic [DATA_BITS-1:0] d);
        int u;
        int s;
        int k;
        u = ucyc(sel);
        s = u * STOP_UNITS_X100 / UNIT_X100;
        speed_sel_i = sel;
        tx_data_i = d;
        tx_valid_i = 1'b1;
        k = 0;
        @(negedge clk_i);
        while (line_tx_o !== LINE_SPACE && k < 8) begin
            k++;
            @(negedge clk_i);
        end
        if (k == 8) timeout();
        tx_valid_i = 1'b0;
        // A changed word mid-character must not reach the line.
        tx_data_i = ~d;
        for (k = 1; k <= 6 * u + s; k++) begin
            @(negedge clk_i);
            if (k == 1) check(tx_ready_o, 8'h00);
            if (k == u - 1) check(line_tx_o, LINE_SPACE);
            if (k >= u && k < 6 * u && k % u == u / 2) check(line_tx_o, d[k / u - 1]);
            if (k == 6 * u) check(line_tx_o, LINE_MARK);
            if (k == 6 * u + s - 1) check({line_tx_o, tx_ready_o}, 8'h02);
            if (k == 6 * u + s) check(tx_ready_o, 8'h01);
        end
        $display("test tx_char done");
    endtask
    task automatic rx_char(input logic [1:0] sel, input logic [DATA_BITS-1:0] d,
                           input logic stop_lvl);
        int u;
        int k;
        u = ucyc(sel);
        speed_sel_i = sel;
        k = 0;
        fork
            partner_u.send(d, u, u * STOP_UNITS_X100 / UNIT_X100, stop_lvl);
            begin
                while (rx_valid_o !== 1'b1 && k < 8 * u) begin
                    @(negedge clk_i);
                    k++;
                end
                if (k == 8 * u) timeout();
                check(rx_data_o, d);
                check(rx_frame_err_o, stop_lvl == LINE_SPACE);
                check(k >= 6 * u + u / 2 && k <= 6 * u + u / 2 + 5, 8'h01);
                @(negedge clk_i);
                check({rx_valid_o, rx_frame_err_o}, 8'h00);
            end
        join
        $display("test rx_char done");
    endtask
    // A spacing blip shorter than half a unit is not a start.
    task automatic rx_glitch();
        int n;
        n = 0;
        speed_sel_i = SPEED_368;
        partner_u.hold(LINE_SPACE, U0 / 4);
        partner_u.hold(LINE_MARK, 1);
        repeat (8 * U0) begin
            @(negedge clk_i);
            if (rx_valid_o !== 1'b0) n++;
        end
        check(8'(n), 8'h00);
        $display("test rx_glitch done");
    endtask
    // Reset in mid-character must return the line to marking at once.
    task automatic tx_abort();
        tx_data_i = 5'h00;
        tx_valid_i = 1'b1;
        repeat (10) @(negedge clk_i);
        tx_valid_i = 1'b0;
        sys_rst_i = 1'b1;
        #1;
        check({line_tx_o, tx_ready_o}, 8'h03);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        $display("test tx_abort done");
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(negedge clk_i);
        reset_values();
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        tx_char(SPEED_368, 5'h15);
        tx_char(SPEED_460, 5'h0a);
        tx_char(SPEED_600, 5'h15);
        tx_char(2'h3, 5'h13);
        rx_char(SPEED_368, 5'h19, LINE_MARK);
        rx_char(SPEED_460, 5'h06, LINE_MARK);
        rx_char(SPEED_600, 5'h1e, LINE_MARK);
        rx_char(SPEED_368, 5'h01, LINE_SPACE);
        repeat (U0) @(negedge clk_i);
        rx_glitch();
        tx_abort();
        tx_char(SPEED_600, 5'h1f);
        finish_test();
    end
endmodule // start_stop_five_unit_codec_test

// ---- unit_timer.sv ----
// Down-counting interval timer with a registered expiry pulse.
`timescale 1ns/100ps
module unit_timer
    import codec_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic                  done_o
);

    logic [CNT_W-1:0] cnt_q;

    // A load of N-1 gives a pulse N-1 edges later, so the owner changes state N edges on.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= !load_i && (cnt_q == CNT_W'(1));
        end
    end

endmodule // unit_timer
